// ===== amp_field_decode.sv
`timescale 1ns/1ns
`default_nettype none

module amp_field_decode (
    input  wire logic [7:0]                    regValue,
    input  wire logic                          hasShield,
    output amp_mod_cfg_pkg::amp_ctrl_t         ctrl
);
    import amp_mod_cfg_pkg::*;

    always_comb begin
        ctrl.sleep          = regValue[SLEEP_BIT];
        ctrl.precisionBoost = regValue[PREC_BIT];
        ctrl.inputSelect    = input_sel_t'(regValue[SEL_HI:SEL_LO]);
        // Shield bit is inverted: a set bit turns the drive off.
        ctrl.shieldEnable   = hasShield & ~regValue[SHIELD_BIT];
        ctrl.gainReserved   = (regValue[GAIN_HI:GAIN_LO] == GAIN_RESERVED);
        // Reserved code yields no gain line rather than an undefined one.
        ctrl.gainFactor     = ctrl.gainReserved ? 7'h00
                            : 7'(8'h01 << regValue[GAIN_HI:GAIN_LO]);
    end

endmodule

`default_nettype wire

// ===== amp_mod_cfg_host.sv
`timescale 1ns/1ns
`default_nettype none

// Host side of the register port. A released request shows inverted address and data,
// so a design that samples an idle bus cannot pass by luck.
module amp_mod_cfg_host (
    input  wire logic                     ref_clk,
    output var  amp_mod_cfg_pkg::reg_req_t req,
    input  wire logic [7:0]               rdata,
    input  wire logic                     rvalid
);
    import amp_mod_cfg_pkg::*;
    initial req = '0;
    task automatic idle();
        req <= '{1'b0, 1'b0, ~req.addr, ~req.wdata};
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk) req <= '{1'b1, 1'b0, a, d};
        @(posedge ref_clk) idle();
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(posedge ref_clk) req <= '{1'b0, 1'b1, a, ~req.wdata};
        @(posedge ref_clk) idle();
        #1;
        d = rdata;
        v = rvalid;
    endtask
endmodule

`default_nettype wire

// ===== amp_mod_cfg_pkg.sv
package amp_mod_cfg_pkg;

    // ********************************************************************
    // Register map
    // ********************************************************************
    localparam logic [7:0] ADDR_CH1_AMP  = 8'h01;
    localparam logic [7:0] ADDR_CH2_AMP  = 8'h02;
    localparam logic [7:0] ADDR_MOD      = 8'h03;
    localparam logic [7:0] ADDR_BIAS     = 8'h04;
    localparam logic [7:0] RESET_VALUE   = 8'h00;

    // Bits that hold state; everything else reads as zero.
    localparam logic [7:0] MASK_CH1_AMP  = 8'hFF;
    localparam logic [7:0] MASK_CH2_AMP  = 8'hF7;
    localparam logic [7:0] MASK_MOD      = 8'hF0;
    localparam logic [7:0] MASK_BIAS     = 8'hBF;

    // ********************************************************************
    // Field positions
    // ********************************************************************
    localparam int SLEEP_BIT    = 7;
    localparam int PREC_BIT     = 6;
    localparam int SEL_HI       = 5;
    localparam int SEL_LO       = 4;
    localparam int SHIELD_BIT   = 3;
    localparam int GAIN_HI      = 2;
    localparam int GAIN_LO      = 0;
    localparam int OFFSET_BIT   = 7;
    localparam int MPREC_BIT    = 6;
    localparam int MSLEEP2_BIT  = 5;
    localparam int MSLEEP1_BIT  = 4;
    localparam int MODLP_BIT    = 7;
    localparam int FIRST_HI     = 5;
    localparam int FIRST_LO     = 4;
    localparam int ROUGH_BIT    = 3;
    localparam int TAIL_BIT     = 2;
    localparam int FIFTH_HI     = 1;
    localparam int FIFTH_LO     = 0;

    localparam logic [2:0] GAIN_RESERVED = 3'h7;

    typedef enum logic [1:0] {
        SEL_TERM,
        SEL_B_ONLY,
        SEL_A_ONLY,
        SEL_A_AND_B
    } input_sel_t;

    // ********************************************************************
    // Carriers
    // ********************************************************************
    typedef struct packed {
        logic       write;
        logic       read;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic       sleep;
        logic       precisionBoost;
        input_sel_t inputSelect;
        logic       shieldEnable;
        logic [6:0] gainFactor;
        logic       gainReserved;
    } amp_ctrl_t;

    typedef struct packed {
        logic       offsetEnable;
        logic       precisionBoost;
        logic       mod2Sleep;
        logic       mod1Sleep;
        logic       modBiasReduced;
        logic [1:0] firstStageBiasScale;
        logic       roughReduced;
        logic       tailReduced;
        logic [1:0] fifthStageBiasScale;
    } mod_ctrl_t;

endpackage

// ===== amp_mod_config_regs.sv
`timescale 1ns/1ns
`default_nettype none

// Contract
// - Channel-1 amp register bit 7 set powers channel-1 amplifier down.
// - Channel-1 amp register bit 6 selects amplifier high-precision mode.
// - Bits 5:4 choose inputs: 11 A+B, 10 A, 01 B, 00 termination.
// - Channel-1 bit 3 inverted: 1 shield drive off, 0 on.
// - Gain bits 2:0 give 2^code, 000..110; 111 is reserved.
// - Channel-2 amp register same layout, bit 3 reserved without shield.
// - Modulator bit 7 inverted: 0 applies built-in offsets, 1 none.
// - Modulator bit 6 enables high precision for both modulators.
// - Modulator bits 5 and 4 power down modulators 2 and 1.
// - Bias bit 7 set reduces modulator bias current.
// - Bias bits 5:4 scale first-stage amplifier bias current.
// - Bias bit 3 reduces rough-phase current, bit 2 tail current.
// - Bias bits 1:0 scale fifth-stage bias; bit 6 reserved.
// - All configuration registers reset to 0x00.
// - Undefined register bits read back as zero.
// - Channel-1 amp register is decoded at address 0x01.
module amp_mod_config_regs (
    input  wire logic                          ref_clk,
    input  wire logic                          resetn,
    input  wire amp_mod_cfg_pkg::reg_req_t     req,
    output logic [7:0]                         rdata,
    output logic                               rvalid,
    output logic                               addrHit,
    output amp_mod_cfg_pkg::amp_ctrl_t         ch1Ctrl,
    output amp_mod_cfg_pkg::amp_ctrl_t         ch2Ctrl,
    output amp_mod_cfg_pkg::mod_ctrl_t         modCtrl
);
    import amp_mod_cfg_pkg::*;

    // ********************************************************************
    // Storage
    // ********************************************************************
    logic [7:0] ch1Amp_ff;
    logic [7:0] ch2Amp_ff;
    logic [7:0] modCfg_ff;
    logic [7:0] biasCfg_ff;
    logic [7:0] nxt_rdata;
    logic       hit;

    function automatic logic [7:0] reg_mask(input logic [7:0] a);
        case (a)
            ADDR_CH1_AMP: reg_mask = MASK_CH1_AMP;
            ADDR_CH2_AMP: reg_mask = MASK_CH2_AMP;
            ADDR_MOD:     reg_mask = MASK_MOD;
            ADDR_BIAS:    reg_mask = MASK_BIAS;
            default:      reg_mask = 8'h00;
        endcase
    endfunction

    // Masking on write keeps reserved bits at zero, so read needs no masking.
    function automatic logic wr_hit(input reg_req_t r, input logic [7:0] a);
        wr_hit = r.write && (r.addr == a);
    endfunction

    assign hit     = (reg_mask(req.addr) != 8'h00);
    assign addrHit = hit;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ch1Amp_ff <= RESET_VALUE;
        end else if (wr_hit(req, ADDR_CH1_AMP)) begin
            ch1Amp_ff <= req.wdata & MASK_CH1_AMP;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ch2Amp_ff <= RESET_VALUE;
        end else if (wr_hit(req, ADDR_CH2_AMP)) begin
            ch2Amp_ff <= req.wdata & MASK_CH2_AMP;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            modCfg_ff <= RESET_VALUE;
        end else if (wr_hit(req, ADDR_MOD)) begin
            modCfg_ff <= req.wdata & MASK_MOD;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            biasCfg_ff <= RESET_VALUE;
        end else if (wr_hit(req, ADDR_BIAS)) begin
            biasCfg_ff <= req.wdata & MASK_BIAS;
        end
    end

    // ********************************************************************
    // Read port
    // ********************************************************************
    always_comb begin
        case (req.addr)
            ADDR_CH1_AMP: nxt_rdata = ch1Amp_ff;
            ADDR_CH2_AMP: nxt_rdata = ch2Amp_ff;
            ADDR_MOD:     nxt_rdata = modCfg_ff;
            ADDR_BIAS:    nxt_rdata = biasCfg_ff;
            default:      nxt_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rdata  <= RESET_VALUE;
            rvalid <= 1'b0;
        end else begin
            rvalid <= req.read;
            if (req.read) begin
                rdata <= nxt_rdata;
            end
        end
    end

    // ********************************************************************
    // Field decode
    // ********************************************************************
    amp_field_decode ch1Decode (
        .regValue  (ch1Amp_ff),
        .hasShield (1'b1),
        .ctrl      (ch1Ctrl)
    );

    // Channel 2 has no shield driver, so bit 3 never reaches an output.
    amp_field_decode ch2Decode (
        .regValue  (ch2Amp_ff),
        .hasShield (1'b0),
        .ctrl      (ch2Ctrl)
    );

    always_comb begin
        modCtrl.offsetEnable        = ~modCfg_ff[OFFSET_BIT];
        modCtrl.precisionBoost      = modCfg_ff[MPREC_BIT];
        modCtrl.mod2Sleep           = modCfg_ff[MSLEEP2_BIT];
        modCtrl.mod1Sleep           = modCfg_ff[MSLEEP1_BIT];
        modCtrl.modBiasReduced      = biasCfg_ff[MODLP_BIT];
        modCtrl.firstStageBiasScale = biasCfg_ff[FIRST_HI:FIRST_LO];
        modCtrl.roughReduced        = biasCfg_ff[ROUGH_BIT];
        modCtrl.tailReduced         = biasCfg_ff[TAIL_BIT];
        modCtrl.fifthStageBiasScale = biasCfg_ff[FIFTH_HI:FIFTH_LO];
    end

endmodule

`default_nettype wire

// ===== amp_mod_config_regs_asserts.sv
`timescale 1ns/1ns
`default_nettype none

module amp_mod_config_regs_asserts (
    input wire logic                       ref_clk,
    input wire logic                       resetn,
    input wire amp_mod_cfg_pkg::reg_req_t  req,
    input wire logic [7:0]                 rdata,
    input wire logic                       rvalid,
    input wire logic                       addrHit,
    input wire amp_mod_cfg_pkg::amp_ctrl_t ch1Ctrl,
    input wire amp_mod_cfg_pkg::amp_ctrl_t ch2Ctrl,
    input wire amp_mod_cfg_pkg::mod_ctrl_t modCtrl
);
    import amp_mod_cfg_pkg::*;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    logic w1;
    logic w2;
    logic w3;
    logic w4;
    assign w1 = req.write && req.addr == ADDR_CH1_AMP;
    assign w2 = req.write && req.addr == ADDR_CH2_AMP;
    assign w3 = req.write && req.addr == ADDR_MOD;
    assign w4 = req.write && req.addr == ADDR_BIAS;
    chk_ch1_power: assert property (
        w1 |=> {ch1Ctrl.sleep, ch1Ctrl.precisionBoost} == $past(req.wdata[7:6]))
        else $error("ch1 power bits wrong");
    chk_ch1_inputs: assert property (
        w1 |=> ch1Ctrl.inputSelect == $past(req.wdata[5:4]))
        else $error("ch1 input select wrong");
    chk_shield_inverted: assert property (
        w1 |=> ch1Ctrl.shieldEnable == !$past(req.wdata[3]))
        else $error("shield polarity wrong");
    chk_gain_decode: assert property (
        w1 |=> {ch1Ctrl.gainReserved, ch1Ctrl.gainFactor} == (8'h01 << $past(req.wdata[2:0])))
        else $error("gain decode wrong");
    chk_ch2_layout: assert property (
        w2 |=> {ch2Ctrl.sleep, ch2Ctrl.precisionBoost, ch2Ctrl.inputSelect,
                ch2Ctrl.shieldEnable} == {$past(req.wdata[7:4]), 1'b0})
        else $error("ch2 fields wrong");
    chk_ch2_gain: assert property (
        w2 |=> {ch2Ctrl.gainReserved, ch2Ctrl.gainFactor} == (8'h01 << $past(req.wdata[2:0])))
        else $error("ch2 gain decode wrong");
    chk_offset_inverted: assert property (
        w3 |=> modCtrl.offsetEnable == !$past(req.wdata[7]))
        else $error("offset polarity wrong");
    chk_mod_modes: assert property (
        w3 |=> {modCtrl.precisionBoost, modCtrl.mod2Sleep, modCtrl.mod1Sleep}
               == $past(req.wdata[6:4]))
        else $error("modulator modes wrong");
    chk_bias_fields: assert property (
        w4 |=> {modCtrl.modBiasReduced, modCtrl.firstStageBiasScale, modCtrl.roughReduced,
                modCtrl.tailReduced, modCtrl.fifthStageBiasScale}
               == {$past(req.wdata[7]), $past(req.wdata[5:0])})
        else $error("bias fields wrong");
    chk_reset_clear: assert property (
        $rose(resetn) |-> rdata == 8'h00 && !rvalid && modCtrl.offsetEnable
                          && ch1Ctrl.shieldEnable)
        else $error("reset state wrong");
    chk_unmapped_zero: assert property (
        req.read && !addrHit |=> rvalid && rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_addr_decode: assert property (
        addrHit == (req.addr >= ADDR_CH1_AMP && req.addr <= ADDR_BIAS))
        else $error("address decode wrong");
endmodule

bind amp_mod_config_regs amp_mod_config_regs_asserts chk (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .req     (req),
    .rdata   (rdata),
    .rvalid  (rvalid),
    .addrHit (addrHit),
    .ch1Ctrl (ch1Ctrl),
    .ch2Ctrl (ch2Ctrl),
    .modCtrl (modCtrl)
);

`default_nettype wire

// ===== tb_amp_mod_config_regs.sv
`timescale 1ns/1ns
`default_nettype none

module tb_amp_mod_config_regs;
    import amp_mod_cfg_pkg::*;
    logic        ref_clk = 1'b0;
    logic        resetn = 1'b0;
    reg_req_t    req;
    logic [7:0]  rdata;
    logic        rvalid;
    logic        addrHit;
    amp_ctrl_t   ch1Ctrl;
    amp_ctrl_t   ch2Ctrl;
    mod_ctrl_t   modCtrl;
    int          mismatches = 0;
    int          totalChecks = 0;
    int          seed = 36243;
    logic [31:0] r;
    logic [7:0]  shadow [0:7] = '{default: 8'h00};
    always #10 ref_clk = ~ref_clk;
    amp_mod_config_regs dut (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .req     (req),
        .rdata   (rdata),
        .rvalid  (rvalid),
        .addrHit (addrHit),
        .ch1Ctrl (ch1Ctrl),
        .ch2Ctrl (ch2Ctrl),
        .modCtrl (modCtrl)
    );
    amp_mod_cfg_host host (.ref_clk(ref_clk), .req(req), .rdata(rdata), .rvalid(rvalid));
    // Stored bits per address; unmapped places keep nothing.
    function automatic logic [7:0] keepMask(input logic [7:0] a);
        case (a)
            8'h01: return 8'hFF;
            8'h02: return 8'hF7;
            8'h03: return 8'hF0;
            8'h04: return 8'hBF;
            default: return 8'h00;
        endcase
    endfunction
    function automatic amp_ctrl_t expAmp(input logic [7:0] d, input logic ch1);
        amp_ctrl_t e;
        e.sleep = d[7];
        e.precisionBoost = d[6];
        e.inputSelect = input_sel_t'(d[5:4]);
        e.shieldEnable = ch1 & ~d[3];
        {e.gainReserved, e.gainFactor} = 8'h01 << d[2:0];
        return e;
    endfunction
    function automatic mod_ctrl_t expMod(input logic [7:0] m, input logic [7:0] b);
        return '{~m[7], m[6], m[5], m[4], b[7], b[5:4], b[3], b[2], b[1:0]};
    endfunction
    task automatic chkCtl(input logic [12:0] got, input logic [12:0] exp);
        totalChecks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chkByte(input logic [7:0] got, input logic [7:0] exp);
        chkCtl({5'h00, got}, {5'h00, exp});
    endtask
    task automatic rdChk(input logic [7:0] a);
        logic [7:0] d;
        logic v;
        host.rd(a, d, v);
        chkByte(d, shadow[a[2:0]]);
        chkByte({7'h00, v}, 8'h01);
    endtask
    task automatic checkOutputs();
        #1;
        chkCtl(ch1Ctrl, expAmp(shadow[1], 1'b1));
        chkCtl(ch2Ctrl, expAmp(shadow[2], 1'b0));
        chkCtl({2'h0, modCtrl}, {2'h0, expMod(shadow[3], shadow[4])});
    endtask
    task automatic wrChk(input logic [7:0] a, input logic [7:0] d);
        host.wr(a, d);
        shadow[a[2:0]] = d & keepMask(a);
        checkOutputs();
        rdChk(a);
    endtask
    task automatic finish_test();
        $display("checks=%0d mismatches=%0d", totalChecks, mismatches);
        if (mismatches == 0 && totalChecks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        #200000;
        mismatches++;
        finish_test();
    end
    initial begin
        repeat (16) @(posedge ref_clk);
        resetn <= 1'b1;
        for (int a = 0; a < 8; a++) rdChk(a[7:0]);
        checkOutputs();
        for (int g = 0; g < 8; g++) begin
            wrChk(8'h01, {g[0], g[1], g[1:0], g[0], g[2:0]});
            wrChk(8'h02, {g[1], g[0], g[1:0], 1'b1, g[2:0]});
        end
        wrChk(8'h02, 8'h80);
        wrChk(8'h03, 8'h40);
        wrChk(8'h03, 8'h3F);
        wrChk(8'h03, 8'h30);
        wrChk(8'h04, 8'hFF);
        wrChk(8'h04, 8'h8F);
        wrChk(8'hFF, 8'h5A);
        repeat (60) begin
            r = $random(seed);
            wrChk({5'h00, r[10:8]}, r[7:0]);
        end
        @(posedge ref_clk) resetn <= 1'b0;
        repeat (2) @(posedge ref_clk);
        resetn <= 1'b1;
        shadow = '{default: 8'h00};
        for (int a = 0; a < 8; a++) rdChk(a[7:0]);
        checkOutputs();
        wrChk(8'h04, 8'h00);
        finish_test();
    end
endmodule

`default_nettype wire
